// ==== acb_bank.v ====
/*
  Auxiliary control register bank with flash configuration word latches,
  reached over APB.
  Assumes flash words arrive on plain inputs from the flash block on pclk,
  and conversion end and programming wait come from logic on pclk.
*/
// The APB register port was left to the implementer.
// How it works
// R1: Delay codes 10/11 time out after 3.6/7.2 ms
// R2: Wide bit selects 8-bit or 16-bit mul/div
// R3: Watchdog kick bit self-clears next cycle
// R4: Timer three reset bit self-clears next cycle
// R5: Bandgap forced on except idle and stop
// R6: Conversion start set by software, hardware clears
// R7: PWM channel zero held while bit set
// R8: PWM channels one to six held together
// R9: Bandgap trim from config word bits 3-0
// R10: Oscillator trim from config word bits 6-0
// R11: Lock bit protects code from readout
// R12: External reset pin honoured only when enabled
// R13: Four-bit code selects low-voltage reset level
// R14: Code 00 disables, 01 times out 0.9 ms
// R15: Config words copied before processor starts
`timescale 1ns/1ps
`default_nettype none
`include "acb_regs.vh"
module acb_bank #(
  parameter TWIDTH = 20
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  flash_bg_word,
  input  wire [7:0]  flash_osc_word,
  input  wire [7:0]  flash_opt_word,
  input  wire        conversion_done,
  input  wire        program_waiting,
  input  wire        idle_or_stop,
  input  wire        ext_reset_pin_n,
  output reg         cpu_release,
  output reg         program_timeout,
  output reg         wide_arithmetic_mode,
  output reg         watchdog_kick,
  output reg         timer_three_reset,
  output reg         bandgap_on,
  output reg         conversion_start,
  output reg         pwm_zero_hold,
  output reg         pwm_group_hold,
  output reg         pointer_bank_select,
  output reg  [3:0]  bandgap_adjust,
  output reg  [6:0]  oscillator_adjust,
  output reg         code_readout_lock,
  output reg         ext_reset_req,
  output reg  [3:0]  low_voltage_reset_level
);

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  // Products are worked out at 32 bits and cut to the counter width on
  // purpose; TWIDTH must hold the longest count
  localparam [31:0]       CNT_SHORT_W = `ACB_T_SHORT_US * `ACB_CLK_MHZ;
  localparam [31:0]       CNT_MID_W   = `ACB_T_MID_US * `ACB_CLK_MHZ;
  localparam [31:0]       CNT_LONG_W  = `ACB_T_LONG_US * `ACB_CLK_MHZ;
  localparam [TWIDTH-1:0] CNT_SHORT   = CNT_SHORT_W[TWIDTH-1:0];
  localparam [TWIDTH-1:0] CNT_MID     = CNT_MID_W[TWIDTH-1:0];
  localparam [TWIDTH-1:0] CNT_LONG    = CNT_LONG_W[TWIDTH-1:0];

  // Load sequencer states
  localparam [1:0] LD_BG   = 2'h0;
  localparam [1:0] LD_OSC  = 2'h1;
  localparam [1:0] LD_OPT  = 2'h2;
  localparam [1:0] LD_DONE = 2'h3;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [7:0]        aux_control_one_q;
  reg  [1:0]        delay_q;
  reg  [1:0]        ld_state_q;
  reg  [1:0]        ld_state_d;
  reg  [7:0]        ld_word;
  reg               rst_meta_q;
  reg               rst_sync_q;
  reg               ext_reset_en_q;
  reg  [1:0]        cfg_index;
  reg  [TWIDTH-1:0] limit;
  wire              timeout;
  wire [7:0]        cfg_rdata;
  wire              wr_en;

  // A write lands only at the edge that completes the access, when the
  // registered pready is high; landing it on the first access edge too
  // would fire the self-clearing strobes twice.
  assign wr_en = psel && penable && pwrite && pready;

  // ----------------------------------------
  // Configuration word load at reset
  // ----------------------------------------
  // One word per cycle after reset is released: trim, oscillator, options.
  // The processor stays held until all three are latched, so it never
  // runs on the reset defaults of the trim and option latches.
  always @* begin
    case (ld_state_q)
      LD_BG:   ld_word = flash_bg_word;
      LD_OSC:  ld_word = flash_osc_word;
      LD_OPT:  ld_word = flash_opt_word;
      default: ld_word = 8'h00;
    endcase
    ld_state_d = (ld_state_q == LD_DONE) ? LD_DONE : ld_state_q + 2'h1;
  end

  // ----------------------------------------
  // Shadow word select
  // ----------------------------------------
  // The whole address is decoded: a slice of it aliases two of the words.
  always @* begin
    case (paddr)
      `ACB_OSC_CFG_ADDR: cfg_index = `ACB_IDX_OSC;
      `ACB_OPT_CFG_ADDR: cfg_index = `ACB_IDX_OPT;
      default:           cfg_index = `ACB_IDX_BG;
    endcase
  end

  acb_cfg_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (ld_state_q != LD_DONE),
    .waddr   (ld_state_q),
    .wdata   (ld_word),
    .raddr   (cfg_index),
    .rdata   (cfg_rdata)
  );

  // Latched fields are taken from the load words directly, so the
  // memory copy is the software-visible view only.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state_q              <= LD_BG;
      cpu_release             <= 1'b0;
      bandgap_adjust          <= 4'h0;
      oscillator_adjust       <= 7'h00;
      code_readout_lock       <= 1'b1;
      low_voltage_reset_level <= 4'h0;
      ext_reset_en_q          <= 1'b0;
    end else begin
      ld_state_q <= ld_state_d;
      case (ld_state_q)
        LD_BG:   bandgap_adjust <= ld_word[3:0]; // R9
        LD_OSC:  oscillator_adjust <= ld_word[6:0]; // R10
        LD_OPT: begin
          code_readout_lock       <= ld_word[`ACB_OPT_LOCK]; // R11
          ext_reset_en_q          <= ld_word[`ACB_OPT_XRST];
          low_voltage_reset_level <= ld_word[`ACB_OPT_LVR_HI:`ACB_OPT_LVR_LO]; // R13
        end
        default: cpu_release <= 1'b1; // R15
      endcase
    end
  end

  // ----------------------------------------
  // External reset pin, synchronised then gated
  // ----------------------------------------
  // The pin is asynchronous to pclk, so two flops come before the gate.
  // The enable latch is set only by the load sequencer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_meta_q    <= 1'b1;
      rst_sync_q    <= 1'b1;
      ext_reset_req <= 1'b0;
    end else begin
      rst_meta_q    <= ext_reset_pin_n;
      rst_sync_q    <= rst_meta_q;
      ext_reset_req <= ext_reset_en_q && !rst_sync_q; // R12
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_control_one_q               <= `ACB_AUX_CONTROL_ONE_RST;
      delay_q              <= `ACB_DELAY_RST;
      wide_arithmetic_mode <= `ACB_WIDE_RST;
    end else begin
      // Self-clearing strobes fall back after one cycle
      aux_control_one_q[`ACB_AUX_CONTROL_ONE_WDT_KICK]  <= 1'b0; // R3
      aux_control_one_q[`ACB_AUX_CONTROL_ONE_TMR3_RST]  <= 1'b0; // R4
      if (conversion_done) begin
        aux_control_one_q[`ACB_AUX_CONTROL_ONE_CONV_START] <= 1'b0; // R6
      end
      if (wr_en && paddr == `ACB_AUX_ONE_ADDR) begin
        // A software set in the done cycle wins over the hardware clear.
        // Bit 1 has no function and always reads back 0.
        aux_control_one_q <= pwdata[7:0] & 8'hFD;
      end
      if (wr_en && paddr == `ACB_AUX_TWO_ADDR) begin
        delay_q              <= pwdata[`ACB_AUX2_DELAY_HI:`ACB_AUX2_DELAY_LO];
        wide_arithmetic_mode <= pwdata[`ACB_AUX2_WIDE]; // R2
      end
    end
  end

  // ----------------------------------------
  // Outputs from the control register and the timer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_kick       <= 1'b0;
      timer_three_reset   <= 1'b0;
      bandgap_on          <= 1'b0;
      conversion_start    <= 1'b0;
      pwm_zero_hold       <= 1'b0;
      pwm_group_hold      <= 1'b0;
      pointer_bank_select <= 1'b0;
      program_timeout     <= 1'b0;
    end else begin
      // Every output is a flop so the far blocks see clean levels
      watchdog_kick       <= aux_control_one_q[`ACB_AUX_CONTROL_ONE_WDT_KICK]; // R3
      timer_three_reset   <= aux_control_one_q[`ACB_AUX_CONTROL_ONE_TMR3_RST]; // R4
      // Auto mode leaves the bandgap to the analog sequencer: report off
      bandgap_on          <= aux_control_one_q[`ACB_AUX_CONTROL_ONE_BG_FORCE] && !idle_or_stop; // R5
      conversion_start    <= aux_control_one_q[`ACB_AUX_CONTROL_ONE_CONV_START]; // R6
      pwm_zero_hold       <= aux_control_one_q[`ACB_AUX_CONTROL_ONE_PWM0_HOLD]; // R7
      pwm_group_hold      <= aux_control_one_q[`ACB_AUX_CONTROL_ONE_PWMG_HOLD]; // R8
      pointer_bank_select <= aux_control_one_q[`ACB_AUX_CONTROL_ONE_PTR_SEL];
      program_timeout     <= timeout;
    end
  end

  // ----------------------------------------
  // Programming wait watchdog
  // ----------------------------------------
  // Code 00 holds the counter clear, so its limit is a don't-care.
  // While the wait lasts the flag repeats once per period.
  always @* begin
    case (delay_q)
      `ACB_DELAY_SHORT: limit = CNT_SHORT; // R14
      `ACB_DELAY_MID:   limit = CNT_MID; // R1
      `ACB_DELAY_LONG:  limit = CNT_LONG; // R1
      default:          limit = CNT_SHORT;
    endcase
  end

  acb_timer #(
    .WIDTH (TWIDTH)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (program_waiting),
    .enable  (delay_q != `ACB_DELAY_OFF), // R14
    .limit   (limit),
    .timeout (timeout)
  );

  // ----------------------------------------
  // APB read and answer: one wait state so the memory read can settle
  // ----------------------------------------
  // Setup at edge 0; the access seen at edge 1 raises pready with prdata;
  // the master samples both at edge 2. Back-to-back transfers are fine
  // since pready drops for a cycle between them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        case (paddr)
          `ACB_AUX_ONE_ADDR:  prdata[7:0] <= aux_control_one_q;
          `ACB_AUX_TWO_ADDR:  prdata[7:0] <= {5'h00, delay_q, wide_arithmetic_mode};
          `ACB_BG_CFG_ADDR,
          `ACB_OSC_CFG_ADDR,
          `ACB_OPT_CFG_ADDR: begin
            // Readback is blocked while the lock is set
            prdata[7:0] <= code_readout_lock ? 8'h00 : cfg_rdata; // R11
            pslverr     <= pwrite;
          end
          // Status word: load finished and the time-out pulse
          `ACB_STATUS_ADDR:   prdata[1:0] <= {cpu_release, program_timeout};
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // acb_bank
`default_nettype wire

// ==== acb_bank_monitor.sv ====
/*
  Port-level assertions for the auxiliary control bank.
  Assumes it is bound to acb_bank and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module acb_bank_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] flash_bg_word,
  input wire logic [7:0] flash_osc_word,
  input wire logic [7:0] flash_opt_word,
  input wire logic       conversion_done,
  input wire logic       program_waiting,
  input wire logic       idle_or_stop,
  input wire logic       cpu_release,
  input wire logic       program_timeout,
  input wire logic       wide_arithmetic_mode,
  input wire logic       watchdog_kick,
  input wire logic       timer_three_reset,
  input wire logic       bandgap_on,
  input wire logic       conversion_start,
  input wire logic       pwm_zero_hold,
  input wire logic       pwm_group_hold,
  input wire logic       pointer_bank_select,
  input wire logic [3:0] bandgap_adjust,
  input wire logic [6:0] oscillator_adjust,
  input wire logic       code_readout_lock,
  input wire logic       ext_reset_req,
  input wire logic [3:0] low_voltage_reset_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_kick_pulse: assert property (watchdog_kick |=> !watchdog_kick)
    else $error("watchdog kick held over one cycle");
  a_tmr_pulse: assert property (timer_three_reset |=> !timer_three_reset)
    else $error("timer three reset held over one cycle");
  a_bg_idle: assert property (idle_or_stop [*2] |-> !bandgap_on)
    else $error("bandgap on in idle or stop");
  a_conv_clear: assert property ((conversion_done && !(psel && pwrite)) |-> ##2 !conversion_start)
    else $error("conversion start not cleared at end");
  a_hold_cause: assert property (($changed(pwm_zero_hold) || $changed(pwm_group_hold) ||
    $changed(pointer_bank_select)) |-> $past(psel && penable && pwrite, 2))
    else $error("hold level changed without a write");
  a_wide_cause: assert property ($changed(wide_arithmetic_mode) |->
    $past(psel && penable && pwrite))
    else $error("width mode changed without a write");
  a_trim_latch: assert property (cpu_release |-> bandgap_adjust == flash_bg_word[3:0] &&
    oscillator_adjust == flash_osc_word[6:0])
    else $error("trim latch differs from flash word");
  a_opt_latch: assert property (cpu_release |-> code_readout_lock == flash_opt_word[7] &&
    low_voltage_reset_level == flash_opt_word[5:2])
    else $error("option latch differs from flash word");
  a_xrst_gate: assert property ((cpu_release && !flash_opt_word[6]) |-> !ext_reset_req)
    else $error("pin reset passed while disabled");
  a_load_time: assert property ($rose(presetn) |-> !cpu_release ##[2:6] cpu_release)
    else $error("config load time wrong");
  a_tmo_pulse: assert property (program_timeout |=> !program_timeout)
    else $error("time-out flag over one cycle");
  a_tmo_idle: assert property (!program_waiting [*3] |-> !program_timeout)
    else $error("time-out without programming wait");
endmodule // acb_bank_monitor
bind acb_bank acb_bank_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .flash_bg_word(flash_bg_word), .flash_osc_word(flash_osc_word),
  .flash_opt_word(flash_opt_word), .conversion_done(conversion_done),
  .program_waiting(program_waiting), .idle_or_stop(idle_or_stop),
  .cpu_release(cpu_release), .program_timeout(program_timeout),
  .wide_arithmetic_mode(wide_arithmetic_mode), .watchdog_kick(watchdog_kick),
  .timer_three_reset(timer_three_reset), .bandgap_on(bandgap_on),
  .conversion_start(conversion_start), .pwm_zero_hold(pwm_zero_hold),
  .pwm_group_hold(pwm_group_hold), .pointer_bank_select(pointer_bank_select),
  .bandgap_adjust(bandgap_adjust), .oscillator_adjust(oscillator_adjust),
  .code_readout_lock(code_readout_lock), .ext_reset_req(ext_reset_req),
  .low_voltage_reset_level(low_voltage_reset_level));
`default_nettype wire

// ==== acb_cfg_mem.v ====
/*
  Shadow memory of the three flash configuration words with registered
  read data.
  Assumes one write port driven by the load sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module acb_cfg_mem (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       we,
  input  wire [1:0] waddr,
  input  wire [7:0] wdata,
  input  wire [1:0] raddr,
  output reg  [7:0] rdata
);

  reg [7:0] mem_q [0:3];
  integer   i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
      rdata <= 8'h00;
    end else begin
      if (we) begin
        mem_q[waddr] <= wdata;
      end
      rdata <= mem_q[raddr];
    end
  end

endmodule // acb_cfg_mem
`default_nettype wire

// ==== acb_regs.vh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  auxiliary control and configuration word bank.
  Assumes a 40 MHz pclk and an APB bus with 32-bit data.
*/
`ifndef ACB_REGS_VH
`define ACB_REGS_VH

// ----------------------------------------
// Register indices and byte addresses on APB
// ----------------------------------------
// Each register takes one aligned word, so its byte address is four
// times its index
`define ACB_AUX_TWO_IDX        16'h00F7
`define ACB_AUX_ONE_IDX        16'h00F8
`define ACB_BG_CFG_IDX         16'h1FFB
`define ACB_OSC_CFG_IDX        16'h1FFD
`define ACB_OPT_CFG_IDX        16'h1FFF
`define ACB_AUX_TWO_ADDR       (`ACB_AUX_TWO_IDX << 2)
`define ACB_AUX_ONE_ADDR       (`ACB_AUX_ONE_IDX << 2)
`define ACB_BG_CFG_ADDR        (`ACB_BG_CFG_IDX << 2)
`define ACB_OSC_CFG_ADDR       (`ACB_OSC_CFG_IDX << 2)
`define ACB_OPT_CFG_ADDR       (`ACB_OPT_CFG_IDX << 2)
`define ACB_STATUS_ADDR        16'h2000
`define ACB_CFG_LOAD_ADDR      16'h2004

// ----------------------------------------
// Configuration word index inside the shadow memory
// ----------------------------------------
`define ACB_IDX_BG             2'h0
`define ACB_IDX_OSC            2'h1
`define ACB_IDX_OPT            2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACB_AUX_CONTROL_ONE_WDT_KICK      7
`define ACB_AUX_CONTROL_ONE_TMR3_RST      6
`define ACB_AUX_CONTROL_ONE_BG_FORCE      5
`define ACB_AUX_CONTROL_ONE_CONV_START    4
`define ACB_AUX_CONTROL_ONE_PWM0_HOLD     3
`define ACB_AUX_CONTROL_ONE_PWMG_HOLD     2
`define ACB_AUX_CONTROL_ONE_PTR_SEL       0
`define ACB_AUX2_DELAY_HI      2
`define ACB_AUX2_DELAY_LO      1
`define ACB_AUX2_WIDE          0
`define ACB_OPT_LOCK           7
`define ACB_OPT_XRST           6
`define ACB_OPT_LVR_HI         5
`define ACB_OPT_LVR_LO         2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACB_AUX_CONTROL_ONE_RST           8'h00
`define ACB_DELAY_RST          2'h3
`define ACB_WIDE_RST           1'h0

// ----------------------------------------
// Delay codes and times in microseconds
// ----------------------------------------
`define ACB_DELAY_OFF          2'h0
`define ACB_DELAY_SHORT        2'h1
`define ACB_DELAY_MID          2'h2
`define ACB_DELAY_LONG         2'h3
`define ACB_T_SHORT_US         900
`define ACB_T_MID_US           3600
`define ACB_T_LONG_US          7200
`define ACB_CLK_MHZ            40

`endif

// ==== acb_timer.v ====
/*
  Programming wait watchdog timer: counts while programming waits and
  pulses a time-out flag when the selected limit is reached.
  Assumes limits are held stable while the wait is in progress.
*/
`timescale 1ns/1ps
`default_nettype none
module acb_timer #(
  parameter WIDTH = 20
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             run,
  input  wire             enable,
  input  wire [WIDTH-1:0] limit,
  output reg              timeout
);

  reg [WIDTH-1:0] count_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= {WIDTH{1'b0}};
      timeout <= 1'b0;
    end else if (!run || !enable) begin
      count_q <= {WIDTH{1'b0}};
      timeout <= 1'b0;
    end else if (count_q == limit - 1'b1) begin
      count_q <= {WIDTH{1'b0}};
      timeout <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
      timeout <= 1'b0;
    end
  end

endmodule // acb_timer
`default_nettype wire

// ==== testbench.sv ====
/*
  Self-checking bench for the auxiliary control bank over APB.
  Assumes the register header and a 40 MHz pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acb_regs.vh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  flash_bg_word, flash_osc_word, flash_opt_word;
  logic        conversion_done, program_waiting, idle_or_stop, ext_reset_pin_n;
  logic        cpu_release, program_timeout, wide_arithmetic_mode, watchdog_kick;
  logic        timer_three_reset, bandgap_on, conversion_start, pwm_zero_hold;
  logic        pwm_group_hold, pointer_bank_select, code_readout_lock, ext_reset_req;
  logic [3:0]  bandgap_adjust, low_voltage_reset_level;
  logic [6:0]  oscillator_adjust;
  integer      fails, n_checks, cyc, kick_n, tmr_n, tmo_n, i;
  acb_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_bg_word(flash_bg_word), .flash_osc_word(flash_osc_word),
    .flash_opt_word(flash_opt_word), .conversion_done(conversion_done),
    .program_waiting(program_waiting), .idle_or_stop(idle_or_stop),
    .ext_reset_pin_n(ext_reset_pin_n), .cpu_release(cpu_release),
    .program_timeout(program_timeout), .wide_arithmetic_mode(wide_arithmetic_mode),
    .watchdog_kick(watchdog_kick), .timer_three_reset(timer_three_reset),
    .bandgap_on(bandgap_on), .conversion_start(conversion_start),
    .pwm_zero_hold(pwm_zero_hold), .pwm_group_hold(pwm_group_hold),
    .pointer_bank_select(pointer_bank_select), .bandgap_adjust(bandgap_adjust),
    .oscillator_adjust(oscillator_adjust), .code_readout_lock(code_readout_lock),
    .ext_reset_req(ext_reset_req), .low_voltage_reset_level(low_voltage_reset_level));
  // ----------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    kick_n += (watchdog_kick === 1'b1);
    tmr_n += (timer_three_reset === 1'b1);
    tmo_n += (program_timeout === 1'b1);
    if (cyc == 90000) begin
      fails++;
      conclude;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Holds the request until pready is sampled high; a dead slave ends at the guard
  task apb(input [15:0] a, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rdc(input [15:0] a, input [31:0] ex, input string nm);
    apb(a, 0, 0);
    chk(nm, ex, q);
    chk("pslverr", 0, e);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, conversion_done, program_waiting, idle_or_stop} = 0;
    paddr = 0; pwdata = 0; ext_reset_pin_n = 1; presetn = 0;
    flash_bg_word = 8'hA5; flash_osc_word = 8'h3C; flash_opt_word = 8'h74;
    {fails, n_checks, cyc, kick_n, tmr_n, tmo_n} = 0;
    tick(2); presetn <= 1; tick(8);
    chk("release", 1, cpu_release);
    chk("bg_adj", 4'h5, bandgap_adjust);
    chk("osc_adj", 7'h3C, oscillator_adjust);
    chk("lock", 0, code_readout_lock);
    chk("lvr", 4'hD, low_voltage_reset_level);
    rdc(`ACB_AUX_ONE_ADDR, 0, "aux_control_one");
    rdc(`ACB_AUX_TWO_ADDR, 8'h06, "aux2");
    rdc(`ACB_BG_CFG_ADDR, 8'hA5, "bg_cfg");
    rdc(`ACB_OSC_CFG_ADDR, 8'h3C, "osc_cfg");
    apb(`ACB_BG_CFG_ADDR, 1, 0); chk("ro_err", 1, e);
    rdc(`ACB_BG_CFG_ADDR, 8'hA5, "bg_kept");
    apb(16'h0100, 0, 0); chk("unmapped", 1, e);
    $display("test reset_and_config done");
    apb(`ACB_AUX_ONE_ADDR, 1, 32'hFD); tick(3);
    chk("kick_n", 1, kick_n);
    chk("tmr_n", 1, tmr_n);
    chk("pwm0", 1, pwm_zero_hold);
    chk("pwmg", 1, pwm_group_hold);
    chk("conv", 1, conversion_start);
    chk("bg_on", 1, bandgap_on);
    chk("ptr", 1, pointer_bank_select);
    rdc(`ACB_AUX_ONE_ADDR, 8'h3D, "aux_control_one_set");
    idle_or_stop <= 1; tick(3);
    chk("bg_idle", 0, bandgap_on);
    idle_or_stop <= 0; conversion_done <= 1; tick(1);
    conversion_done <= 0; tick(2);
    chk("conv_end", 0, conversion_start);
    rdc(`ACB_AUX_ONE_ADDR, 8'h2D, "aux_control_one_end");
    apb(`ACB_AUX_ONE_ADDR, 1, 0); tick(2);
    chk("pwm0_run", 0, pwm_zero_hold);
    chk("pwmg_run", 0, pwm_group_hold);
    chk("bg_auto", 0, bandgap_on);
    chk("ptr_clr", 0, pointer_bank_select);
    apb(`ACB_AUX_TWO_ADDR, 1, 1); tick(2);
    chk("wide", 1, wide_arithmetic_mode);
    rdc(`ACB_AUX_TWO_ADDR, 1, "aux2_wide");
    apb(`ACB_AUX_TWO_ADDR, 1, 32'h00000004);
    rdc(`ACB_AUX_TWO_ADDR, 8'h04, "aux2_mid");
    ext_reset_pin_n <= 0; tick(6);
    chk("xrst_on", 1, ext_reset_req);
    ext_reset_pin_n <= 1; tick(6);
    $display("test aux_control done");
    // 0.9 ms at 40 MHz is 36000 cycles; the longer codes would overrun the run
    apb(`ACB_AUX_TWO_ADDR, 1, 2); program_waiting <= 1; i = 0;
    while (program_timeout !== 1'b1 && i < 40000) begin
      tick(1); i++;
    end
    chk("t_short", 1, i >= 35990 && i <= 36010);
    apb(`ACB_AUX_TWO_ADDR, 1, 0); tmo_n = 0; tick(37000);
    chk("t_off", 0, tmo_n);
    program_waiting <= 0;
    $display("test program_watchdog done");
    presetn <= 0; flash_opt_word <= 8'h80; tick(2); presetn <= 1; tick(8);
    chk("lock_on", 1, code_readout_lock);
    chk("lvr_min", 0, low_voltage_reset_level);
    rdc(`ACB_OSC_CFG_ADDR, 0, "locked");
    ext_reset_pin_n <= 0; tick(6);
    chk("xrst_off", 0, ext_reset_req);
    $display("test locked_config done");
    conclude;
  end
endmodule // testbench
`default_nettype wire
